//--- inc/hsps_map.svh
// Constants for the host serial port select block
`ifndef HSPS_MAP_SVH
`define HSPS_MAP_SVH
`define HSPS_CLK_HZ 100000000
`define HSPS_UART_BAUD 9600
`define HSPS_BAUD_DIV (`HSPS_CLK_HZ / `HSPS_UART_BAUD)
`define HSPS_RXB_DEPTH 128
`define HSPS_CTS_HIGH_GAP 17
`define HSPS_CTS_LOW_FREE 34
`define HSPS_RTS_SLIP 5
`define HSPS_FIFO_DEPTH 8
`define HSPS_SPI_HALF 15
`define HSPS_PKT_MAX 100
`define HSPS_PIN_PERIPH 3'h1
`define HSPS_FMT_UNESC 2'h1
`define HSPS_ATTN_DEFAULT 3'h0
`endif

//--- inc/hsps_pkg.sv
// Types shared by both ends of the host serial port select link
package hsps_pkg;
    typedef enum {HSPS_SEL_BOTH, HSPS_SEL_UART, HSPS_SEL_SPI} hsps_sel_t;
    typedef logic [7:0] hsps_byte_t;
endpackage : hsps_pkg

//--- inc/hsps_if.sv
// Pins between the device and the host microcontroller
`timescale 1ns/10ps
interface hsps_if;
    logic uart_rx;          // Host to device UART line, strap at reset
    logic uart_tx_o;        // Device UART line output
    logic uart_tx_oe;       // Device drives UART line
    logic uart_tx_host_o;   // Host pull of transmit strap
    logic uart_tx_host_oe;  // Host drives strap low
    logic cts_b;            // Device CTS, high means stop
    logic rts_b;            // Host RTS, high means stop
    logic data_present_b;   // Device indicator, low when UART data queued
    logic spi_clk;          // Master clock
    logic spi_ssel_b;       // Master select, low active
    logic spi_mosi;         // Master out
    logic spi_miso_o;       // Slave out value
    logic spi_miso_oe;      // Slave drives out line
    logic attn_b;           // Device attention, low active
    wire uart_tx = uart_tx_host_oe ? uart_tx_host_o : (uart_tx_oe ? uart_tx_o : 1'b1);
    wire spi_miso = spi_miso_oe ? spi_miso_o : 1'b1;
    modport dev (input uart_rx, uart_tx, rts_b, spi_clk, spi_ssel_b, spi_mosi,
                 output uart_tx_o, uart_tx_oe, cts_b, data_present_b, spi_miso_o, spi_miso_oe, attn_b);
    modport host (input uart_tx, cts_b, data_present_b, spi_miso, attn_b,
                  output uart_rx, uart_tx_host_o, uart_tx_host_oe, rts_b, spi_clk, spi_ssel_b, spi_mosi);
endinterface : hsps_if

//--- rtl/hsps_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module hsps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage words
    logic [AW-1:0] wr_r;             // Write pointer
    logic [AW-1:0] rd_r;             // Read pointer
    logic [AW:0] cnt_r;              // Fill count
    logic push;
    logic pop;

    // Honest flags from the count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_r];
    assign level = cnt_r;

    // Storage write, no reset needed for data
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : hsps_fifo

//--- rtl/hsps_dev.sv
// Device end: UART/SPI port selection, SPI slave, buffers and flow control
`timescale 1ns/10ps
`include "hsps_map.svh"
module hsps_dev import hsps_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    hsps_if.dev pins,
    input wire logic [2:0] uart_receive_pin_function,
    input wire logic [2:0] uart_transmit_pin_function,
    input wire logic [2:0] spi_pin_function_first,
    input wire logic [2:0] spi_pin_function_last,
    input wire logic [2:0] attention_pin_function,
    input wire logic [1:0] host_frame_format_select,
    input wire logic rts_control_enable,
    input wire logic cts_control_enable,
    input wire logic data_present_indicator,
    input wire logic write_command,
    input wire logic pkt_valid,
    input wire logic [6:0] pkt_len,
    input wire logic [7:0] pkt_data,
    output logic pkt_ready,
    output logic pkt_dropped,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overflow,
    output logic command_mode,
    output logic [2:0] attention_active_function,
    output logic spi_active,
    output logic [1:0] active_frame_format,
    output logic config_stored
);
    // Pin synchronisers, two stages each
    logic [1:0] s_rx, s_tx, s_rts, s_clk, s_ssel, s_mosi;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_rx <= 2'h3; s_tx <= 2'h3; s_rts <= 2'h3;
            s_clk <= 2'h0; s_ssel <= 2'h3; s_mosi <= 2'h0;
        end else begin
            s_rx <= {s_rx[0], pins.uart_rx};
            s_tx <= {s_tx[0], pins.uart_tx};
            s_rts <= {s_rts[0], pins.rts_b};
            s_clk <= {s_clk[0], pins.spi_clk};
            s_ssel <= {s_ssel[0], pins.spi_ssel_b};
            s_mosi <= {s_mosi[0], pins.spi_mosi};
        end
    end
    wire rx_s = s_rx[1];
    wire rts_s = s_rts[1];
    wire ssel_s = s_ssel[1];
    wire mosi_s = s_mosi[1];

    // Port enables from pin functions
    function automatic logic is_periph(input logic [2:0] f);
        return f == `HSPS_PIN_PERIPH;
    endfunction : is_periph
    wire uart_cfg = is_periph(uart_receive_pin_function) && is_periph(uart_transmit_pin_function);
    wire spi_cfg = is_periph(spi_pin_function_first) && is_periph(spi_pin_function_last);

    // Straps caught once the pin synchronisers hold real pin levels
    logic strap_done_r, forced_spi_r, forced_uart_r, stored_spi_r;
    logic [1:0] strap_cnt_r; // Edges since reset release, saturates at two
    // The rx and tx synchronisers leave reset high, so straps are read on the third edge
    wire strap_take = !strap_done_r && (strap_cnt_r == 2'h2);
    wire strap_spi = strap_take && rx_s && !s_tx[1];
    hsps_sel_t sel_r;
    logic clk_d_r, ssel_d_r;
    logic [2:0] rbit_r;
    logic [7:0] rsh_r;
    logic uart_in_ev;
    wire clk_rise = s_clk[1] && !clk_d_r;
    wire clk_fall = !s_clk[1] && clk_d_r;
    wire spi_sel = !ssel_s;
    wire spi_byte_done = spi_sel && clk_rise && (rbit_r == 3'h7);

    // Persistent forced-SPI state; stands in for flash, so device reset leaves it alone
    logic stored_cfg_r = 1'b0; // Power-on value: nothing written yet
    always_ff @(posedge core_clk) begin
        if (write_command && forced_spi_r) begin
            stored_cfg_r <= 1'b1;
        end
    end
    assign config_stored = stored_cfg_r;

    // Strap wait counter
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt_r <= 2'h0;
        end else if (strap_cnt_r != 2'h2) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // Strap capture and initial selection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_r <= 1'b0;
            forced_spi_r <= 1'b0;
            forced_uart_r <= 1'b0;
            stored_spi_r <= 1'b0;
            sel_r <= HSPS_SEL_UART;
        end else if (strap_take) begin
            strap_done_r <= 1'b1;
            stored_spi_r <= config_stored;
            if (!rx_s) begin
                forced_uart_r <= 1'b1;
                sel_r <= HSPS_SEL_UART;
            end else if (!s_tx[1]) begin
                forced_spi_r <= 1'b1;
                sel_r <= HSPS_SEL_SPI;
            end else if (config_stored || (spi_cfg && !uart_cfg)) begin
                sel_r <= HSPS_SEL_SPI;
            end else if (spi_cfg && uart_cfg) begin
                sel_r <= HSPS_SEL_BOTH;
            end else begin
                sel_r <= HSPS_SEL_UART;
            end
        end else if (sel_r == HSPS_SEL_BOTH) begin
            if (spi_sel) begin
                sel_r <= HSPS_SEL_SPI;
            end else if (uart_in_ev) begin
                sel_r <= HSPS_SEL_UART;
            end
        end
    end
    assign spi_active = strap_done_r && (sel_r == HSPS_SEL_SPI);
    assign command_mode = forced_uart_r;
    assign attention_active_function = ((forced_spi_r || stored_spi_r) &&
        attention_pin_function == `HSPS_ATTN_DEFAULT) ? `HSPS_PIN_PERIPH : attention_pin_function;
    assign active_frame_format = spi_active ? `HSPS_FMT_UNESC : host_frame_format_select;
    wire uart_out = strap_done_r && (sel_r != HSPS_SEL_SPI);

    // UART receiver, 9600 baud, start bit detection
    logic [13:0] ubaud_r;
    logic [3:0] ubit_r;
    logic [7:0] ush_r;
    logic ubusy_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ubaud_r <= '0; ubit_r <= '0; ush_r <= '0; ubusy_r <= 1'b0; uart_in_ev <= 1'b0;
        end else begin
            uart_in_ev <= 1'b0;
            if (!ubusy_r) begin
                if (!rx_s && strap_done_r && uart_out) begin
                    ubusy_r <= 1'b1;
                    ubaud_r <= 14'(`HSPS_BAUD_DIV / 2);
                    ubit_r <= '0;
                end
            end else if (ubaud_r != '0) begin
                ubaud_r <= ubaud_r - 14'h1;
            end else begin
                ubaud_r <= 14'(`HSPS_BAUD_DIV - 1);
                ubit_r <= ubit_r + 4'h1;
                if (ubit_r >= 4'h1 && ubit_r <= 4'h8) begin
                    ush_r <= {rx_s, ush_r[7:1]};
                end
                if (ubit_r == 4'h9) begin
                    ubusy_r <= 1'b0;
                    uart_in_ev <= 1'b1;
                end
            end
        end
    end

    // SPI receive shifter, mode 0 MSB first
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_d_r <= 1'b0; ssel_d_r <= 1'b1; rbit_r <= '0; rsh_r <= '0;
        end else begin
            clk_d_r <= s_clk[1];
            ssel_d_r <= ssel_s;
            if (!spi_sel) begin
                rbit_r <= '0;
            end else if (clk_rise) begin
                rsh_r <= {rsh_r[6:0], mosi_s};
                rbit_r <= rbit_r + 3'h1;
            end
        end
    end

    // Receive buffer with CTS thresholds and overflow discard
    logic [7:0] rxb [`HSPS_RXB_DEPTH];
    logic [6:0] rxw_r, rxr_r;
    logic [7:0] rxc_r;
    wire in_ev = (uart_in_ev && uart_out) || (spi_byte_done && spi_active);
    wire [7:0] in_byte = uart_in_ev ? ush_r : {rsh_r[6:0], mosi_s};
    wire rx_full = (rxc_r == 8'(`HSPS_RXB_DEPTH));
    wire rx_push = in_ev && !rx_full;
    wire rx_pop = rx_valid && rx_ready;
    assign rx_valid = (rxc_r != '0);
    assign rx_data = rxb[rxr_r];
    always_ff @(posedge core_clk) begin
        if (rx_push) begin
            rxb[rxw_r] <= in_byte;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxw_r <= '0; rxr_r <= '0; rxc_r <= '0; rx_overflow <= 1'b0; pins.cts_b <= 1'b0;
        end else begin
            rx_overflow <= in_ev && rx_full;
            if (rx_push) rxw_r <= rxw_r + 7'h1;
            if (rx_pop) rxr_r <= rxr_r + 7'h1;
            rxc_r <= rxc_r + 8'(rx_push) - 8'(rx_pop);
            if (!cts_control_enable) begin
                pins.cts_b <= 1'b0;
            end else if (rxc_r >= 8'(`HSPS_RXB_DEPTH - `HSPS_CTS_HIGH_GAP)) begin
                pins.cts_b <= 1'b1;
            end else if (rxc_r <= 8'(`HSPS_RXB_DEPTH - `HSPS_CTS_LOW_FREE)) begin
                pins.cts_b <= 1'b0;
            end
        end
    end

    // Transmit FIFO in the outbound path
    logic st_pend_r;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_in_data, f_out_data;
    logic [3:0] f_level;
    hsps_fifo #(.WIDTH(8), .DEPTH(`HSPS_FIFO_DEPTH)) i_hsps_fifo (
        .core_clk(core_clk), .rst_b(rst_b),
        .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(f_in_data),
        .out_valid(f_out_valid), .out_ready(f_out_ready), .out_data(f_out_data),
        .level(f_level)
    );
    // Packet admitted only if room for it, or for eight bytes when longer; else dropped
    logic [6:0] pkt_left_r;
    wire room = (4'(`HSPS_FIFO_DEPTH) - f_level) >= 4'(pkt_len > 7'h8 ? 4'h8 : pkt_len[3:0]);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pkt_left_r <= '0; pkt_dropped <= 1'b0; st_pend_r <= 1'b0;
        end else begin
            pkt_dropped <= 1'b0;
            if (strap_spi) begin
                st_pend_r <= 1'b1;
            end else if (st_pend_r && f_in_ready) begin
                st_pend_r <= 1'b0;
            end
            if (pkt_valid && pkt_left_r == '0 && !st_pend_r) begin
                if (room && pkt_len != '0) begin
                    pkt_left_r <= pkt_len - 7'h1;
                end else begin
                    pkt_dropped <= 1'b1;
                end
            end else if (pkt_valid && pkt_left_r != '0 && f_in_ready) begin
                pkt_left_r <= pkt_left_r - 7'h1;
            end
        end
    end
    wire pkt_first = pkt_valid && pkt_left_r == '0 && !st_pend_r && room && pkt_len != '0;
    assign f_in_valid = st_pend_r || pkt_first || (pkt_valid && pkt_left_r != '0);
    assign f_in_data = st_pend_r ? 8'h7E : pkt_data; // Status frame opens with delimiter
    assign pkt_ready = !st_pend_r && f_in_ready && (pkt_first || pkt_left_r != '0);

    // UART transmitter, RTS gated
    logic [13:0] tbaud_r;
    logic [3:0] tbit_r;
    logic [8:0] tsh_r;
    logic tbusy_r;
    wire uart_take = uart_out && !tbusy_r && f_out_valid && !(rts_control_enable && rts_s);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tbaud_r <= '0; tbit_r <= '0; tsh_r <= 9'h1FF; tbusy_r <= 1'b0;
        end else if (uart_take) begin
            tbusy_r <= 1'b1;
            tsh_r <= {f_out_data, 1'b0};
            tbaud_r <= 14'(`HSPS_BAUD_DIV - 1);
            tbit_r <= '0;
        end else if (tbusy_r) begin
            if (tbaud_r != '0) begin
                tbaud_r <= tbaud_r - 14'h1;
            end else begin
                tbaud_r <= 14'(`HSPS_BAUD_DIV - 1);
                tsh_r <= {1'b1, tsh_r[8:1]};
                tbit_r <= tbit_r + 4'h1;
                if (tbit_r == 4'h9) tbusy_r <= 1'b0;
            end
        end
    end
    assign pins.uart_tx_o = tsh_r[0];
    assign pins.uart_tx_oe = uart_out;
    assign pins.data_present_b = !(data_present_indicator && uart_out && f_out_valid);

    // SPI transmit serializer
    logic [7:0] tx_sh_r;
    logic [2:0] tbits_r;
    logic tx_have_r, miso_r, miso_oe_r;
    wire spi_load = spi_active && spi_sel && !tx_have_r && f_out_valid;
    assign f_out_ready = uart_take || spi_load;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_r <= '0; tbits_r <= '0; tx_have_r <= 1'b0; miso_r <= 1'b0; miso_oe_r <= 1'b0;
        end else begin
            miso_oe_r <= spi_active && spi_sel;
            if (ssel_s && !ssel_d_r) begin
                miso_oe_r <= 1'b0;
            end
            if (spi_load) begin
                tx_sh_r <= f_out_data;
                tx_have_r <= 1'b1;
                tbits_r <= '0;
                miso_r <= f_out_data[7];
            end else if (spi_sel && clk_fall && tx_have_r) begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                tbits_r <= tbits_r + 3'h1;
                if (tbits_r == 3'h7) begin
                    tx_have_r <= 1'b0; // Last bit stays on the line
                end else begin
                    miso_r <= tx_sh_r[6];
                end
            end
        end
    end
    assign pins.spi_miso_o = miso_r;
    assign pins.spi_miso_oe = miso_oe_r;
    assign pins.attn_b = !(spi_active && (f_out_valid || tx_have_r));
endmodule : hsps_dev

//--- rtl/hsps_host.sv
// Host end: SPI master, UART peer pins and reset straps
`timescale 1ns/10ps
`include "hsps_map.svh"
module hsps_host import hsps_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    hsps_if.host pins,
    input wire logic force_spi,
    input wire logic force_uart,
    input wire logic uart_rx_level,
    input wire logic rts_hold,
    input wire logic xfer_start,
    input wire logic [7:0] xfer_tx,
    output logic xfer_busy,
    output logic [7:0] xfer_rx,
    output logic xfer_done,
    output logic frame_byte_valid
);
    // Synchronise device outputs
    logic [1:0] s_miso, s_attn;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_miso <= 2'h3; s_attn <= 2'h3;
        end else begin
            s_miso <= {s_miso[0], pins.spi_miso};
            s_attn <= {s_attn[0], pins.attn_b};
        end
    end

    // Straps: hold transmit low until attention asserts
    logic strap_hold_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_hold_r <= 1'b1;
        end else if (!s_attn[1]) begin
            strap_hold_r <= 1'b0;
        end
    end
    assign pins.uart_tx_host_o = 1'b0;
    assign pins.uart_tx_host_oe = force_spi && strap_hold_r;
    assign pins.uart_rx = force_uart ? 1'b0 : uart_rx_level;
    assign pins.rts_b = rts_hold;

    // SPI master, mode 0, clock divided within rate limit
    logic [3:0] div_r;
    logic [3:0] nbit_r;
    logic sclk_r, sel_r, in_frame_r;
    logic mbit_r; // Slave bit taken at the rising edge, shifted in at the fall
    logic [7:0] sh_r;
    wire tick = (div_r == 4'(`HSPS_SPI_HALF - 1));
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0; nbit_r <= '0; sclk_r <= 1'b0; sel_r <= 1'b0;
            sh_r <= '0; xfer_rx <= '0; xfer_done <= 1'b0; mbit_r <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            div_r <= (tick || !sel_r) ? '0 : div_r + 4'h1;
            if (!sel_r) begin
                if (xfer_start) begin
                    sel_r <= 1'b1;
                    sh_r <= xfer_tx;
                    nbit_r <= '0;
                end
            end else if (tick) begin
                if (!sclk_r && nbit_r == 4'h8) begin
                    sel_r <= 1'b0;
                    xfer_done <= 1'b1;
                    xfer_rx <= sh_r;
                end else if (!sclk_r) begin
                    sclk_r <= 1'b1;
                    mbit_r <= s_miso[1]; // Sample on the rising edge
                end else begin
                    // Out line moves only here, so it is steady at the next rise
                    sclk_r <= 1'b0;
                    sh_r <= {sh_r[6:0], mbit_r};
                    nbit_r <= nbit_r + 4'h1;
                end
            end
        end
    end
    assign pins.spi_clk = sclk_r;
    assign pins.spi_ssel_b = !sel_r;
    assign pins.spi_mosi = sh_r[7];
    assign xfer_busy = sel_r;

    // Frame filter: bytes before a delimiter are discarded
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_frame_r <= 1'b0;
        end else if (xfer_done && xfer_rx == 8'h7E) begin
            in_frame_r <= 1'b1;
        end
    end
    assign frame_byte_valid = xfer_done && (in_frame_r || xfer_rx == 8'h7E);
endmodule : hsps_host

//--- dv/hsps_checker.sv
// Concurrent checks on the pins between device and host
`timescale 1ns/10ps
module hsps_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic spi_clk,
    input wire logic spi_ssel_b,
    input wire logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe,
    input wire logic attn_b,
    input wire logic cts_b,
    input wire logic uart_tx_oe,
    input wire logic uart_tx_host_oe
);
    // Single domain, so one clock and one reset for all
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> attn_b && !cts_b && !spi_miso_oe)
        else $error("outputs not quiet after reset");
    AST_MISO_ONLY_SEL: assert property (spi_ssel_b [*5] |-> !spi_miso_oe)
        else $error("slave output driven while deselected");
    AST_MISO_FLOAT: assert property ($rose(spi_ssel_b) |-> ##[0:3] !spi_miso_oe)
        else $error("slave output not floated after deselect");
    AST_MISO_HOLD: assert property ($rose(spi_clk) && !spi_ssel_b |-> $stable(spi_miso_o) [*3])
        else $error("slave output moved at sampling edge");
    AST_MOSI_HOLD: assert property ($rose(spi_clk) |-> $stable(spi_mosi))
        else $error("master output moved at sampling edge");
    AST_CLK_IDLE: assert property (spi_ssel_b |-> !spi_clk)
        else $error("serial clock not idle low");
    // Low phase long enough keeps the rate in bounds
    AST_CLK_RATE: assert property ($fell(spi_clk) |-> !spi_clk [*8])
        else $error("serial clock too fast");
    AST_UART_OFF: assert property (uart_tx_host_oe && $past(uart_tx_host_oe, 4) |-> !uart_tx_oe)
        else $error("uart driven during strap");
    // Attention may only clear after a transfer
    AST_ATTN_HOLD: assert property (!attn_b && spi_ssel_b [*8] |=> !attn_b)
        else $error("attention dropped without transfer");
    // Main scenarios reached
    cover property ($fell(attn_b));
    cover property ($rose(spi_ssel_b));
    cover property ($fell(uart_tx_host_oe));
endmodule : hsps_checker

//--- dv/hsps_test.sv
// Bench joining device and host ends across the pin interface
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module hsps_test;
    int n_fail = 0;
    int num_checks = 0;
    logic core_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, saw_drop = 1'b0;
    logic [2:0] uf = 3'h1, sf = 3'h1, apf = 3'h0, aaf;
    logic [1:0] fmt = 2'h0, aff;
    logic pkt_valid = 1'b0, rx_ready = 1'b0, pkt_ready, pkt_dropped, rx_valid;
    logic command_mode, spi_active, config_stored, xfer_done;
    logic force_spi = 1'b0, force_uart = 1'b0, uart_rx_level = 1'b1, rts_hold = 1'b0, xfer_start = 1'b0;
    logic [6:0] pkt_len = 7'h00;
    logic [7:0] pkt_data = 8'h00, xfer_tx = 8'h00, rx_data, xfer_rx, exp_b, last_b;
    logic [7:0] q[$]; // Expected bytes from the slave
    hsps_if bus();
    hsps_dev i_hsps_dev (.core_clk, .rst_b, .pins(bus.dev), .uart_receive_pin_function(uf),
        .uart_transmit_pin_function(uf), .spi_pin_function_first(sf), .spi_pin_function_last(sf),
        .attention_pin_function(apf), .host_frame_format_select(fmt), .rts_control_enable(1'b1),
        .cts_control_enable(1'b1), .data_present_indicator(1'b1), .write_command(wr), .pkt_valid,
        .pkt_len, .pkt_data, .pkt_ready, .pkt_dropped, .rx_data, .rx_valid, .rx_ready, .rx_overflow(),
        .command_mode, .attention_active_function(aaf), .spi_active, .active_frame_format(aff), .config_stored);
    hsps_host i_hsps_host (.core_clk, .rst_b, .pins(bus.host), .force_spi, .force_uart, .uart_rx_level,
        .rts_hold, .xfer_start, .xfer_tx, .xfer_busy(), .xfer_rx, .xfer_done, .frame_byte_valid());
    hsps_checker i_hsps_checker (.core_clk, .rst_b, .spi_clk(bus.spi_clk), .spi_ssel_b(bus.spi_ssel_b),
        .spi_mosi(bus.spi_mosi), .spi_miso_o(bus.spi_miso_o), .spi_miso_oe(bus.spi_miso_oe),
        .attn_b(bus.attn_b), .cts_b(bus.cts_b), .uart_tx_oe(bus.uart_tx_oe), .uart_tx_host_oe(bus.uart_tx_host_oe));
    always #5 core_clk = ~core_clk;
    // Compare each finished byte with the oldest note
    always @(posedge core_clk) begin
        if (pkt_dropped === 1'b1) saw_drop <= 1'b1;
        if (xfer_done === 1'b1 && q.size() > 0) begin
            exp_b = q.pop_front();
            `CHK(xfer_rx, exp_b)
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // Straps held through reset, forced SPI held until attention
    task automatic do_reset(input logic [2:0] u, input logic [2:0] s, input logic fs, input logic rl);
        int w;
        rst_b = 1'b0;
        {uf, sf, force_spi, force_uart, uart_rx_level} = {u, s, fs, !rl, rl};
        apf = 3'($urandom_range(0, 2));
        fmt = 2'($urandom_range(0, 3));
        rts_hold = 1'($urandom);
        tick(12);
        rst_b = 1'b1;
        for (w = 0; w < 300 && fs && bus.attn_b !== 1'b0; w++) tick(1);
        tick(10);
        {force_spi, force_uart, uart_rx_level} = 3'b001;
    endtask : do_reset
    // One byte each way; the received byte must reach the buffer
    task automatic xfer(input logic [7:0] tx);
        int w;
        xfer_tx = tx;
        xfer_start = 1'b1;
        tick(1);
        xfer_start = 1'b0;
        for (w = 0; w < 600 && xfer_done !== 1'b1; w++) tick(1);
        `CHK(xfer_done, 1'b1)
        for (w = 0; w < 60 && rx_valid !== 1'b1; w++) tick(1);
        `CHK(rx_data, tx)
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(20);
    endtask : xfer
    // Radio packet into the transmit path; a dropped one is not noted
    task automatic send_pkt(input int n, input logic drop);
        int k;
        int w;
        for (k = 0; k < n; k++) begin
            {pkt_data, pkt_len, pkt_valid} = {8'($urandom), 7'(n), 1'b1};
            for (w = 0; w < 50; w++) begin
                @(posedge core_clk);
                if (pkt_ready === 1'b1 || pkt_dropped === 1'b1) break;
            end
            #1;
            if (!drop) q.push_back(pkt_data);
            if (!drop) last_b = pkt_data;
        end
        pkt_valid = 1'b0;
        tick(5);
    endtask : send_pkt
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // Hang guard, several times the few thousand cycles the run needs
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
    initial begin
        int k;
        k = $urandom(7486);
        // Port choice from pin functions, before anything is stored
        for (k = 0; k < 4; k++) begin
            do_reset(3'(k & 1), 3'(k >> 1), 1'b0, 1'b1);
            `CHK(spi_active, k == 2)
            if (k == 3) begin
                xfer(8'($urandom));
                `CHK(spi_active, 1'b1)
            end
        end
        do_reset(3'h1, 3'h1, 1'b1, 1'b1);
        `CHK(spi_active, 1'b1)
        `CHK(aaf, (apf == 3'h0) ? 3'h1 : apf)
        `CHK(aff, 2'h1)
        `CHK(bus.attn_b, 1'b0)
        q.push_back(8'h7E); // Status frame first
        xfer(8'($urandom));
        `CHK(bus.attn_b, 1'b1)
        q.push_back(8'h00); // Last bit of status byte repeats
        xfer(8'($urandom));
        send_pkt(8, 1'b0);
        send_pkt(2, 1'b1);
        `CHK(saw_drop, 1'b1)
        for (k = 0; k < 8; k++) xfer(8'($urandom));
        q.push_back({8{last_b[0]}}); // Empty buffer repeats last bit
        xfer(8'($urandom));
        wr = 1'b1;
        tick(2);
        wr = 1'b0;
        `CHK(config_stored, 1'b1)
        // Stored config survives reset and starts in SPI with no strap
        do_reset(3'h1, 3'h1, 1'b0, 1'b1);
        `CHK(spi_active, 1'b1)
        `CHK(aaf, (apf == 3'h0) ? 3'h1 : apf)
        do_reset(3'h0, 3'h1, 1'b0, 1'b0);
        `CHK(command_mode, 1'b1)
        `CHK(spi_active, 1'b0)
        `CHK(q.size(), 0)
        stop_test();
    end
endmodule : hsps_test
